// ===== core/sri_pkg.sv
// Function
// - pointer write, restart, incrementing read, nack stop
// - read from current pointer until nack stop
// - enabled: finished measurement raises flag, pin low
// - flag and pin held until cleared
// - status read or reset mode clears both
// - ready pin is open drain only
// - ready pin released right after power-up
// - host clears pending interrupt before disabling
// - host sends nothing before power is up
// - host waits ready low, reads status, data
// - fixed seven-bit target address on both ends
// - status offset holds data-ready flag bit zero
// - pressure bytes fetched in one continuous read
`default_nettype none
package sri_pkg;

  localparam logic [6:0] DEV_ADDR      = 7'h5d;
  localparam logic [7:0] STATUS_OFS    = 8'h19;
  localparam int         RDY_FLAG_BIT  = 0;
  localparam logic [7:0] PRESS_MSB_OFS = 8'h1a;
  localparam logic [7:0] PRESS_LSB_OFS = 8'h1b;
  localparam logic [7:0] PRESS_XL_OFS  = 8'h1c;
  localparam logic [7:0] TEMP_MSB_OFS  = 8'h1d;
  localparam logic [7:0] TEMP_LSB_OFS  = 8'h1e;
  localparam logic [7:0] PTR_RST       = 8'h00;

  // serial clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC   = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // host controller registers
  localparam logic [7:0] HREG_CTRL  = 8'h00;
  localparam logic [7:0] HREG_STAT  = 8'h04;
  localparam logic [7:0] HREG_RDATA = 8'h08;
  localparam logic [7:0] HREG_IRQ   = 8'h0c;
  localparam logic [7:0] HREG_MASK  = 8'h10;

  localparam int CTRL_PTR_LSB   = 0;
  localparam int CTRL_CNT_LSB   = 8;
  localparam int CTRL_USEPTR    = 12;
  localparam int CTRL_GO        = 16;

  localparam int STAT_BUSY      = 0;
  localparam int STAT_NACK      = 1;
  localparam int STAT_PIN       = 2;

  localparam int IRQ_DONE       = 0;
  localparam int IRQ_NACK       = 1;
  localparam int IRQ_READY      = 2;
  localparam logic [2:0] MASK_RST = 3'h0;

endpackage
`default_nettype wire

// ===== core/sri_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sri_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_rdy_o;
  logic dev_rdy_oe;
  logic scl;
  logic sda;
  logic ready_pin_n;

  // wired-and with pull-ups: a line is low only while someone drives low
  assign scl   = ~(host_scl_oe & ~host_scl_o);
  assign sda   = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  assign ready_pin_n = ~(dev_rdy_oe & ~dev_rdy_o);

  modport device (
    input  scl, sda, ready_pin_n,
    output dev_sda_o, dev_sda_oe, dev_rdy_o, dev_rdy_oe
  );
  modport host (
    input  scl, sda, ready_pin_n,
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe
  );
endinterface
`default_nettype wire

// ===== core/sri_target.sv
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sri_target (
  input  wire logic        clock,            // system clock
  input  wire logic        rst,              // async reset, active high
  sri_link_if.device       link,             // serial bus and ready pin
  input  wire logic        meas_done,        // strobe: a measurement finished
  input  wire logic [21:0] press_in,         // pressure msb, lsb, 6-bit extension
  input  wire logic [15:0] temp_in,          // temperature msb, lsb
  input  wire logic        ready_irq_enable, // level: interrupt enabled
  input  wire logic        reset_mode,       // level: reset mode set
  output logic             data_ready_flag,  // level: interrupt pending
  output logic             wr_valid,         // strobe: host wrote a data byte
  output logic [7:0]       wr_addr,          // register written
  output logic [7:0]       wr_data           // byte written
);

  typedef enum logic [4:0] {
    T_IDLE = 5'h01,
    T_RX   = 5'h02,
    T_ACK  = 5'h04,
    T_TX   = 5'h08,
    T_HACK = 5'h10
  } sri_tst_type;

  typedef struct packed {
    sri_tst_type st;
    logic [1:0]  scl_s;   // [0] first synchroniser stage
    logic [1:0]  sda_s;
    logic        scl_d;
    logic        sda_d;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        first;   // next received byte is the address
    logic        is_ptr;  // next received byte is the pointer
    logic        rd;
    logic        sda_oe;
    logic [7:0]  ptr;
    logic [21:0] press;
    logic [15:0] temp;
    logic        flag;
    logic        wr_v;
    logic [7:0]  wa;
    logic [7:0]  wd;
  } sri_tstate_type;

  sri_tstate_type s_ff;
  sri_tstate_type nxt_s;

  function automatic logic [7:0] reg_byte(
    input logic [7:0]  a,
    input logic [21:0] p,
    input logic [15:0] t,
    input logic        f
  );
    logic [7:0] r;
    r = 8'h00;
    if (a == sri_pkg::STATUS_OFS) begin
      r[sri_pkg::RDY_FLAG_BIT] = f;
    end else if (a == sri_pkg::PRESS_MSB_OFS) begin
      r = p[21:14];
    end else if (a == sri_pkg::PRESS_LSB_OFS) begin
      r = p[13:6];
    end else if (a == sri_pkg::PRESS_XL_OFS) begin
      r = {p[5:0], 2'h0};
    end else if (a == sri_pkg::TEMP_MSB_OFS) begin
      r = t[15:8];
    end else if (a == sri_pkg::TEMP_LSB_OFS) begin
      r = t[7:0];
    end
    return r;
  endfunction

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic load;
    rise  = 1'b0;
    fall  = 1'b0;
    start = 1'b0;
    stop  = 1'b0;
    load  = 1'b0;
    nxt_s = s_ff;
    nxt_s.scl_s = {s_ff.scl_s[0], link.scl};
    nxt_s.sda_s = {s_ff.sda_s[0], link.sda};
    nxt_s.scl_d = s_ff.scl_s[1];
    nxt_s.sda_d = s_ff.sda_s[1];
    nxt_s.wr_v  = 1'b0;
    rise  = s_ff.scl_s[1] & ~s_ff.scl_d;
    fall  = ~s_ff.scl_s[1] & s_ff.scl_d;
    // start and stop only count while the clock is stably high
    start = s_ff.scl_s[1] & s_ff.scl_d & s_ff.sda_d & ~s_ff.sda_s[1];
    stop  = s_ff.scl_s[1] & s_ff.scl_d & ~s_ff.sda_d & s_ff.sda_s[1];

    if (start) begin
      nxt_s.st     = T_RX;
      nxt_s.bitn   = 4'h0;
      nxt_s.first  = 1'b1;
      nxt_s.sda_oe = 1'b0;
    end else if (stop) begin
      nxt_s.st     = T_IDLE;
      nxt_s.sda_oe = 1'b0;
    end else begin
      case (s_ff.st)
        T_RX: begin
          if (rise && s_ff.bitn < 4'h8) begin
            nxt_s.sh   = {s_ff.sh[6:0], s_ff.sda_s[1]};
            nxt_s.bitn = s_ff.bitn + 4'h1;
          end
          if (fall && s_ff.bitn == 4'h8) begin
            nxt_s.st     = T_ACK;
            nxt_s.sda_oe = 1'b1;
            nxt_s.first  = 1'b0;
            if (s_ff.first) begin
              if (s_ff.sh[7:1] == sri_pkg::DEV_ADDR) begin
                nxt_s.rd     = s_ff.sh[0];
                nxt_s.is_ptr = ~s_ff.sh[0];
              end else begin
                nxt_s.st     = T_IDLE;
                nxt_s.sda_oe = 1'b0;
              end
            end else if (s_ff.is_ptr) begin
              nxt_s.ptr    = s_ff.sh;
              nxt_s.is_ptr = 1'b0;
            end else begin
              nxt_s.wr_v = 1'b1;
              nxt_s.wa   = s_ff.ptr;
              nxt_s.wd   = s_ff.sh;
              nxt_s.ptr  = s_ff.ptr + 8'h01;
            end
          end
        end
        T_ACK: begin
          if (fall) begin
            if (s_ff.rd) begin
              load = 1'b1;
            end else begin
              nxt_s.st     = T_RX;
              nxt_s.bitn   = 4'h0;
              nxt_s.sda_oe = 1'b0;
            end
          end
        end
        T_TX: begin
          if (fall) begin
            if (s_ff.bitn == 4'h7) begin
              nxt_s.st     = T_HACK;
              nxt_s.sda_oe = 1'b0;
            end else begin
              nxt_s.sh     = {s_ff.sh[6:0], 1'b0};
              nxt_s.sda_oe = ~s_ff.sh[6];
              nxt_s.bitn   = s_ff.bitn + 4'h1;
            end
          end
        end
        T_HACK: begin
          // an ack reuses the ack state so the next falling edge loads a byte
          if (rise) begin
            nxt_s.st = s_ff.sda_s[1] ? T_IDLE : T_ACK;
          end
        end
        default: begin
        end
      endcase
    end

    if (load) begin
      nxt_s.st     = T_TX;
      nxt_s.bitn   = 4'h0;
      nxt_s.sh     = reg_byte(s_ff.ptr, s_ff.press, s_ff.temp, s_ff.flag);
      nxt_s.sda_oe = ~nxt_s.sh[7];
      nxt_s.ptr    = s_ff.ptr + 8'h01;
    end

    // data may change mid-read; a meas_done between byte loads mixes old and new bytes
    if (meas_done) begin
      nxt_s.press = press_in;
      nxt_s.temp  = temp_in;
    end

    // the enable input alone never clears a pending flag
    if ((load && s_ff.ptr == sri_pkg::STATUS_OFS) || reset_mode) begin
      nxt_s.flag = 1'b0;
    end
    // set wins over a same-cycle clear
    if (meas_done && ready_irq_enable) begin
      nxt_s.flag = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_ff        <= '0;
      s_ff.st     <= T_IDLE;
      s_ff.scl_s  <= 2'h3;
      s_ff.sda_s  <= 2'h3;
      s_ff.scl_d  <= 1'b1;
      s_ff.sda_d  <= 1'b1;
      s_ff.ptr    <= sri_pkg::PTR_RST;
      s_ff.flag   <= 1'b0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.dev_sda_o   = 1'b0;
  assign link.dev_sda_oe  = s_ff.sda_oe;
  assign link.dev_rdy_o   = 1'b0;
  assign link.dev_rdy_oe  = s_ff.flag;
  assign data_ready_flag  = s_ff.flag;
  assign wr_valid         = s_ff.wr_v;
  assign wr_addr          = s_ff.wa;
  assign wr_data          = s_ff.wd;

endmodule
`default_nettype wire

// ===== core/sri_host.sv
`timescale 1ns/10ps
`default_nettype none
module sri_host #(
  parameter int QUARTER_CYCLES = sri_pkg::QUARTER_CYC // quarter serial clock period
) (
  input  wire logic        clock,    // system clock
  input  wire logic        rst,      // async reset, active high
  sri_link_if.host         link,     // serial bus and ready pin
  input  wire logic [7:0]  sw_addr,  // register byte address
  input  wire logic [31:0] sw_wdata, // write data
  input  wire logic        sw_wr,    // write strobe
  input  wire logic        sw_rd,    // read strobe
  output logic      [31:0] sw_rdata, // read data, cycle after the strobe
  output logic             irq       // level: unmasked event pending
);

  // below four cycles a quarter the device sync delay eats the data setup
  if (QUARTER_CYCLES < 4 || QUARTER_CYCLES > 65535) begin : g_chk
    $error("QUARTER_CYCLES out of range");
  end

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_STA  = 5'h02,
    H_WB   = 5'h04,
    H_RB   = 5'h08,
    H_STP  = 5'h10
  } sri_hst_type;

  typedef struct packed {
    sri_hst_type st;
    logic [1:0]  ph;
    logic [15:0] cnt;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [1:0]  seg;    // 0 address-write, 1 pointer, 2 address-read
    logic [1:0]  left;
    logic [1:0]  idx;
    logic [7:0]  ptr;
    logic        nack;
    logic [31:0] rdata;
    logic        scl_oe;
    logic        sda_oe;
    logic [1:0]  sda_s;  // [0] first synchroniser stage
    logic [1:0]  rdy_s;
    logic        rdy_d;
    logic [2:0]  irq_st;
    logic [2:0]  mask;
    logic [31:0] rd_q;
  } sri_hstate_type;

  sri_hstate_type s_ff;
  sri_hstate_type nxt_s;

  // returns {scl_oe, sda_oe} for a phase of a state
  function automatic logic [1:0] drive(
    input sri_hst_type st,
    input logic [1:0]  ph,
    input logic [3:0]  b,
    input logic        d7,
    input logic        more
  );
    logic lo;
    lo = (ph == 2'h0) || (ph == 2'h3);
    case (st)
      H_STA:   drive = {ph != 2'h1 && ph != 2'h2 || ph == 2'h3, ph[1]};
      H_WB:    drive = {lo, (b < 4'h8) ? ~d7 : 1'b0};
      H_RB:    drive = {lo, (b == 4'h8) ? more : 1'b0};
      H_STP:   drive = {ph == 2'h0, ph[1] == 1'b0};
      default: drive = 2'h0;
    endcase
  endfunction

  always_comb begin
    logic       tick;
    logic [2:0] ev;
    logic [1:0] dv;
    tick  = 1'b0;
    ev    = 3'h0;
    dv    = 2'h0;
    nxt_s = s_ff;
    nxt_s.sda_s = {s_ff.sda_s[0], link.sda};
    nxt_s.rdy_s = {s_ff.rdy_s[0], link.ready_pin_n};
    nxt_s.rdy_d = s_ff.rdy_s[1];
    tick = (s_ff.st != H_IDLE) && (s_ff.cnt == 16'(QUARTER_CYCLES - 1));
    if (s_ff.st != H_IDLE) begin
      nxt_s.cnt = tick ? 16'h0000 : s_ff.cnt + 16'h0001;
    end
    if (tick) begin
      nxt_s.ph = s_ff.ph + 2'h1;
      case (s_ff.st)
        H_STA: begin
          if (s_ff.ph == 2'h3) begin
            nxt_s.st   = H_WB;
            nxt_s.bitn = 4'h0;
            nxt_s.sh   = {sri_pkg::DEV_ADDR, s_ff.seg != 2'h0};
          end
        end
        H_WB: begin
          if (s_ff.ph == 2'h1 && s_ff.bitn == 4'h8) begin
            nxt_s.nack = s_ff.sda_s[1];
          end
          if (s_ff.ph == 2'h3) begin
            nxt_s.bitn = s_ff.bitn + 4'h1;
            nxt_s.sh   = {s_ff.sh[6:0], 1'b0};
            if (s_ff.bitn == 4'h8) begin
              nxt_s.bitn = 4'h0;
              if (s_ff.nack) begin
                nxt_s.st = H_STP;
              end else if (s_ff.seg == 2'h0) begin
                nxt_s.seg = 2'h1;
                nxt_s.sh  = s_ff.ptr;
              end else if (s_ff.seg == 2'h1) begin
                nxt_s.seg = 2'h2;
                nxt_s.st  = H_STA;
              end else begin
                nxt_s.st = H_RB;
              end
            end
          end
        end
        H_RB: begin
          if (s_ff.ph == 2'h1 && s_ff.bitn < 4'h8) begin
            nxt_s.sh = {s_ff.sh[6:0], s_ff.sda_s[1]};
          end
          if (s_ff.ph == 2'h3) begin
            nxt_s.bitn = s_ff.bitn + 4'h1;
            if (s_ff.bitn == 4'h7) begin
              nxt_s.rdata[{s_ff.idx, 3'h0} +: 8] = s_ff.sh;
            end else if (s_ff.bitn == 4'h8) begin
              // bytes follow in one unbroken read; the device may still update data between them
              nxt_s.bitn = 4'h0;
              nxt_s.left = s_ff.left - 2'h1;
              nxt_s.idx  = s_ff.idx + 2'h1;
              if (s_ff.left == 2'h0) begin
                nxt_s.st = H_STP;
              end
            end
          end
        end
        H_STP: begin
          if (s_ff.ph == 2'h3) begin
            nxt_s.st            = H_IDLE;
            ev[sri_pkg::IRQ_DONE] = 1'b1;
            ev[sri_pkg::IRQ_NACK] = s_ff.nack;
          end
        end
        default: begin
        end
      endcase
    end

    // commands only start while the controller is idle
    if (sw_wr && sw_addr == sri_pkg::HREG_CTRL && sw_wdata[sri_pkg::CTRL_GO]
        && s_ff.st == H_IDLE) begin
      nxt_s.st    = H_STA;
      nxt_s.ph    = 2'h0;
      nxt_s.cnt   = 16'h0000;
      nxt_s.ptr   = sw_wdata[sri_pkg::CTRL_PTR_LSB +: 8];
      nxt_s.left  = sw_wdata[sri_pkg::CTRL_CNT_LSB +: 2];
      nxt_s.idx   = 2'h0;
      nxt_s.nack  = 1'b0;
      nxt_s.rdata = 32'h0000_0000;
      nxt_s.seg   = sw_wdata[sri_pkg::CTRL_USEPTR] ? 2'h0 : 2'h2;
    end
    if (sw_wr && sw_addr == sri_pkg::HREG_MASK) begin
      nxt_s.mask = sw_wdata[2:0];
    end

    // ready pin falling marks a finished measurement
    ev[sri_pkg::IRQ_READY] = s_ff.rdy_d & ~s_ff.rdy_s[1];

    nxt_s.rd_q = 32'h0000_0000;
    if (sw_rd) begin
      if (sw_addr == sri_pkg::HREG_STAT) begin
        nxt_s.rd_q[sri_pkg::STAT_BUSY] = s_ff.st != H_IDLE;
        nxt_s.rd_q[sri_pkg::STAT_NACK] = s_ff.nack;
        nxt_s.rd_q[sri_pkg::STAT_PIN]  = s_ff.rdy_s[1];
      end else if (sw_addr == sri_pkg::HREG_RDATA) begin
        nxt_s.rd_q = s_ff.rdata;
      end else if (sw_addr == sri_pkg::HREG_IRQ) begin
        nxt_s.rd_q[2:0] = s_ff.irq_st;
        nxt_s.irq_st    = 3'h0;
      end else if (sw_addr == sri_pkg::HREG_MASK) begin
        nxt_s.rd_q[2:0] = s_ff.mask;
      end
    end
    nxt_s.irq_st = nxt_s.irq_st | ev;

    dv = drive(nxt_s.st, nxt_s.ph, nxt_s.bitn, nxt_s.sh[7], nxt_s.left != 2'h0);
    nxt_s.scl_oe = dv[1];
    nxt_s.sda_oe = dv[0];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_ff       <= '0;
      s_ff.st    <= H_IDLE;
      s_ff.sda_s <= 2'h3;
      s_ff.rdy_s <= 2'h3;
      s_ff.rdy_d <= 1'b1;
      s_ff.mask  <= sri_pkg::MASK_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.host_scl_o  = 1'b0;
  assign link.host_scl_oe = s_ff.scl_oe;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = s_ff.sda_oe;
  assign sw_rdata         = s_ff.rd_q;
  assign irq              = |(s_ff.irq_st & s_ff.mask);

endmodule
`default_nettype wire

// ===== sim/sri_checker.sv
`timescale 1ns/10ps
`default_nettype none
module sri_checker (
  input wire logic clock,       // system clock
  input wire logic rst,         // async reset, active high
  input wire logic host_scl_oe, // host pulls scl low
  input wire logic host_sda_oe, // host pulls sda low
  input wire logic dev_sda_o,   // device sda level
  input wire logic dev_sda_oe,  // device pulls sda low
  input wire logic dev_rdy_o,   // device ready level
  input wire logic dev_rdy_oe,  // device pulls ready low
  input wire logic scl,         // resolved clock line
  input wire logic sda,         // resolved data line
  input wire logic ready_pin_n  // resolved ready line
);
  logic       scl_ff;
  logic       sda_ff;
  logic       in_addr_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] addr_sh_ff;
  logic       ack_slot;

  // own edge detect so start and ack slots need no sampled functions outside properties
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_ff     <= 1'b1;
      sda_ff     <= 1'b1;
      in_addr_ff <= 1'b0;
      bit_cnt_ff <= 4'h0;
      addr_sh_ff <= 8'h00;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
      if (scl && scl_ff && sda_ff && !sda) begin
        in_addr_ff <= 1'b1;
        bit_cnt_ff <= 4'h0;
      end else if (in_addr_ff && scl && !scl_ff) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        if (bit_cnt_ff == 4'h8) begin
          in_addr_ff <= 1'b0;
        end else begin
          addr_sh_ff <= {addr_sh_ff[6:0], sda};
        end
      end
    end
  end

  assign ack_slot = in_addr_ff && (bit_cnt_ff == 4'h8) && scl && !scl_ff;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_start;
    scl && scl_ff && sda_ff && !sda;
  endsequence
  sequence s_own_ack;
    ack_slot && (addr_sh_ff[7:1] == sri_pkg::DEV_ADDR);
  endsequence
  sequence s_other_ack;
    ack_slot && (addr_sh_ff[7:1] != sri_pkg::DEV_ADDR);
  endsequence

  property p_rdy_od;
    dev_rdy_oe |-> (dev_rdy_o == 1'b0) && !ready_pin_n;
  endproperty
  property p_sda_od;
    dev_sda_oe |-> dev_sda_o == 1'b0;
  endproperty
  property p_rdy_reset;
    disable iff (1'b0) rst |-> !dev_rdy_oe && ready_pin_n && !dev_sda_oe;
  endproperty
  property p_host_reset;
    disable iff (1'b0) rst |-> !host_scl_oe && !host_sda_oe;
  endproperty
  property p_rdy_hold;
    $rose(dev_rdy_oe) |=> dev_rdy_oe [*3];
  endproperty
  property p_dev_edge;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  property p_quiet_addr;
    s_start |=> !dev_sda_oe [*8];
  endproperty
  property p_ack_own;
    s_own_ack |-> dev_sda_oe && !sda;
  endproperty
  property p_no_ack_other;
    s_other_ack |-> !dev_sda_oe;
  endproperty

  a_rdy_od:       assert property (p_rdy_od) else $error("ready pin driven high");
  a_sda_od:       assert property (p_sda_od) else $error("data line driven high");
  a_rdy_reset:    assert property (p_rdy_reset) else $error("pin active in reset");
  a_host_reset:   assert property (p_host_reset) else $error("host busy in reset");
  a_rdy_hold:     assert property (p_rdy_hold) else $error("ready pin dropped");
  a_dev_edge:     assert property (p_dev_edge) else $error("data moved, clock high");
  a_quiet_addr:   assert property (p_quiet_addr) else $error("device drove address");
  a_ack_own:      assert property (p_ack_own) else $error("own address not acked");
  a_no_ack_other: assert property (p_no_ack_other) else $error("foreign address acked");
endmodule
`default_nettype wire

// ===== sim/sri_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sensor_i2c_read_and_ready_irq_bench;
  logic        clock;
  logic        rst;
  logic        meas_done;
  logic [21:0] press_in;
  logic [15:0] temp_in;
  logic        ready_irq_enable;
  logic        reset_mode;
  logic        data_ready_flag;
  logic [7:0]  sw_addr;
  logic [31:0] sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [31:0] sw_rdata;
  logic        irq;
  logic [31:0] rd;
  int          n_errors;
  int          cmp_count;

  sri_link_if link ();
  sri_target sri_target_i (.clock(clock), .rst(rst), .link(link.device),
    .meas_done(meas_done), .press_in(press_in), .temp_in(temp_in),
    .ready_irq_enable(ready_irq_enable), .reset_mode(reset_mode),
    .data_ready_flag(data_ready_flag), .wr_valid(), .wr_addr(), .wr_data());
  // short quarter keeps every transfer at or below about a thousand cycles
  sri_host #(.QUARTER_CYCLES(4)) sri_host_i (.clock(clock), .rst(rst), .link(link.host),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .irq(irq));
  sri_checker sri_checker_i (.clock(clock), .rst(rst), .host_scl_oe(link.host_scl_oe),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .dev_rdy_o(link.dev_rdy_o), .dev_rdy_oe(link.dev_rdy_oe), .scl(link.scl),
    .sda(link.sda), .ready_pin_n(link.ready_pin_n));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    sw_wr    <= 1'b1;
    sw_addr  <= a;
    sw_wdata <= d;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    sw_rd   <= 1'b1;
    sw_addr <= a;
    @(posedge clock);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  // runs one serial read and leaves the received bytes in rd
  task automatic xfer(input logic [7:0] ptr, input logic [1:0] cnt_m1, input logic useptr);
    int i;
    sw_write(sri_pkg::HREG_CTRL, {15'h0000, 1'b1, 3'h0, useptr, 2'h0, cnt_m1, ptr});
    for (i = 0; i < 2000; i++) begin
      sw_read(sri_pkg::HREG_STAT, rd);
      if (rd[sri_pkg::STAT_BUSY] === 1'b0) break;
    end
    chk("busy", 32'h0, {31'h0, rd[sri_pkg::STAT_BUSY]});
    sw_read(sri_pkg::HREG_RDATA, rd);
  endtask

  task automatic meas_strobe;
    @(posedge clock);
    meas_done <= 1'b1;
    @(posedge clock);
    meas_done <= 1'b0;
    #1;
  endtask

  task automatic pin_state(input logic flag);
    chk("flag", {31'h0, flag}, {31'h0, data_ready_flag});
    chk("ready_pin_n", {31'h0, ~flag}, {31'h0, link.ready_pin_n});
  endtask

  initial begin
    n_errors = 0;
    cmp_count = 0;
    rst = 1'b0;
    meas_done = 1'b0;
    press_in = 22'h2ab5c3;
    temp_in = 16'h1e7f;
    ready_irq_enable = 1'b1;
    reset_mode = 1'b0;
    sw_addr = 8'h00;
    sw_wdata = 32'h0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    // a real rising edge of reset, so no flop misses it at time zero
    #1 rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    #1 pin_state(1'b0);
    sw_read(sri_pkg::HREG_MASK, rd);
    chk("mask", 32'h0, rd);
    sw_write(sri_pkg::HREG_MASK, 32'h7);
    meas_strobe();
    pin_state(1'b1);
    repeat (20) @(posedge clock);
    #1 pin_state(1'b1);
    sw_read(sri_pkg::HREG_STAT, rd);
    chk("stat", 32'h0, rd);
    chk("irq", 32'h1, {31'h0, irq});
    sw_read(sri_pkg::HREG_IRQ, rd);
    chk("irq_stat", 32'h4, rd);
    xfer(sri_pkg::STATUS_OFS, 2'h3, 1'b1);
    chk("rdata", {press_in[5:0], 2'h0, press_in[13:6], press_in[21:14], 8'h01}, rd);
    pin_state(1'b0);
    sw_read(sri_pkg::HREG_STAT, rd);
    chk("stat", 32'h4, rd);
    sw_read(sri_pkg::HREG_IRQ, rd);
    chk("irq_stat", 32'h1, rd);
    xfer(8'h00, 2'h1, 1'b0);
    chk("rdata", {16'h0, temp_in[7:0], temp_in[15:8]}, {16'h0, rd[15:0]});
    xfer(8'h00, 2'h0, 1'b0);
    chk("rdata", 32'h0, {24'h0, rd[7:0]});
    xfer(sri_pkg::STATUS_OFS, 2'h0, 1'b1);
    chk("status", 32'h0, {24'h0, rd[7:0]});
    meas_strobe();
    repeat (5) @(posedge clock);
    reset_mode <= 1'b1;
    @(posedge clock);
    reset_mode <= 1'b0;
    #1 pin_state(1'b0);
    meas_strobe();
    xfer(sri_pkg::STATUS_OFS, 2'h0, 1'b1);
    chk("status", 32'h1, {24'h0, rd[7:0]});
    @(posedge clock);
    ready_irq_enable <= 1'b0;
    meas_strobe();
    pin_state(1'b0);
    sw_read(sri_pkg::HREG_IRQ, rd);
    sw_write(sri_pkg::HREG_MASK, 32'h0);
    xfer(sri_pkg::STATUS_OFS, 2'h0, 1'b1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    sw_write(sri_pkg::HREG_MASK, 32'h1);
    @(posedge clock);
    #1 chk("irq", 32'h1, {31'h0, irq});
    sw_read(sri_pkg::HREG_IRQ, rd);
    chk("irq_stat", 32'h1, rd);
    @(posedge clock);
    #1 chk("irq_clear", 32'h0, {31'h0, irq});
    end_of_test();
  end

  // transfers take at most about a thousand cycles each, so this is far beyond the run
  initial begin
    #400000;
    n_errors++;
    $display("unexpected watchdog: expected done, seen hang");
    end_of_test();
  end
endmodule
`default_nettype wire
